// ### dpllrc_freq_calc.v
// Reference-3 frequency calculator: base rate x multiplier x numerator / denominator
`timescale 1ns/1ps
`include "dpllrc_map.vh"
module dpllrc_freq_calc (
   input wire clk,
   input wire rst,
   input wire start,
   input wire [15:0] base_rate_value,
   input wire [15:0] base_multiplier_value,
   input wire [15:0] fec_numerator_value,
   input wire [15:0] fec_denominator_value,
   output reg [47:0] ref_freq_hz,
   output reg busy
);
   // ==========================================================
   // Sequential restoring divider, one quotient bit per cycle
   // Trades 48 cycles of latency for a single small subtractor
   // ==========================================================
   reg [47:0] dividend_q;
   reg [63:0] rem_q;
   reg [15:0] den_q;
   reg [5:0] cnt_q;
   wire [31:0] base_product = base_rate_value * base_multiplier_value; // [R10]
   wire [47:0] full_product = base_product * fec_numerator_value; // [R01]
   wire [63:0] shifted_rem = {rem_q[62:0], dividend_q[47]};
   wire fits = shifted_rem >= {48'h0, den_q};
   always @(posedge clk) begin
      if (rst) begin
         dividend_q <= 48'h0;
         rem_q <= 64'h0;
         den_q <= 16'h1;
         cnt_q <= 6'h0;
         busy <= 1'b0;
         ref_freq_hz <= 48'h0;
      end else if (start) begin
         dividend_q <= full_product;
         rem_q <= 64'h0;
         // Zero denominator would hang the quotient at all ones; treat as one
         den_q <= (fec_denominator_value == 16'h0) ? 16'h1 : fec_denominator_value;
         cnt_q <= `DPLLRC_CALC_STEPS;
         busy <= 1'b1;
      end else if (busy) begin
         rem_q <= fits ? (shifted_rem - {48'h0, den_q}) : shifted_rem;
         dividend_q <= {dividend_q[46:0], fits};
         cnt_q <= cnt_q - 6'h1;
         if (cnt_q == 6'h1) begin
            busy <= 1'b0;
            ref_freq_hz <= {dividend_q[46:0], fits}; // [R01]
         end
      end
   end
endmodule // dpllrc_freq_calc

// ### dpllrc_host.sv
// Host software model driving the byte register port
`timescale 1ns/1ps
module dpllrc_host (
   input wire clk,
   input wire [7:0] rdata,
   output reg wr, rd,
   output reg [7:0] addr, wdata
);
   initial {wr, rd, addr, wdata} = 18'h00000;
   task wr8(input [7:0] a, input [7:0] d);
      @(negedge clk) {wr, addr, wdata} <= {1'b1, a, d};
      @(negedge clk) wr <= 1'b0;
   endtask
   task rd8(input [7:0] a, output [7:0] d);
      @(negedge clk) {rd, addr} <= {1'b1, a};
      @(negedge clk) rd <= 1'b0;
      d = rdata;
   endtask
   task wr32(input [7:0] a, input [31:0] w); // Top byte first
      integer i;
      for (i = 0; i < 4; i++) wr8(a + i[7:0], w[31 - 8 * i -: 8]);
   endtask
   task ctl(input [2:0] bw, input rl, input [1:0] sl); // Reserved bits kept 00
      wr8(8'h30, {bw, rl, sl, 2'b00});
   endtask
endmodule // dpllrc_host

// ### dpllrc_map.vh
// Register map, field positions, reset values and loop-setting codes
`ifndef DPLLRC_MAP_VH
`define DPLLRC_MAP_VH
`define DPLLRC_ADDR_RATIO_B0 8'h2c
`define DPLLRC_ADDR_RATIO_B3 8'h2f
`define DPLLRC_ADDR_LOOP_CTRL 8'h30
`define DPLLRC_ADDR_VAR_BW 8'hbb
`define DPLLRC_RATIO_RESET 32'h00010001
`define DPLLRC_LOOP_CTRL_RESET 8'h0c
`define DPLLRC_DENOM_LSB 0
`define DPLLRC_DENOM_MSB 15
`define DPLLRC_NUMER_LSB 16
`define DPLLRC_NUMER_MSB 31
`define DPLLRC_RSVD_MSB 1
`define DPLLRC_SLOPE_LSB 2
`define DPLLRC_SLOPE_MSB 3
`define DPLLRC_REALIGN_BIT 4
`define DPLLRC_BW_LSB 5
`define DPLLRC_BW_MSB 7
`define DPLLRC_BW_VARIABLE 3'h7
`define DPLLRC_SLOPE_UNLIMITED 2'h3
`define DPLLRC_SLOPE_61US 2'h0
`define DPLLRC_SLOPE_7P5US 2'h1
`define DPLLRC_SLOPE_0P885US 2'h2
`define DPLLRC_FEC_ONE 16'h0001
`define DPLLRC_BW_BASE_HZ 10'd14
`define DPLLRC_CALC_STEPS 6'd48
`endif

// ### dpllrc_regs.v
// Loop ratio and control register bank for the tracking loop, reference input 3
//
// Contract
// [R01] The reference-3 frequency is base rate times multiplier times numerator over denominator.
// [R02] Software sets numerator and denominator to one for a plain reference; that is also reset.
// [R03] The ratio word holds the denominator in bits 15:0 and the numerator in bits 31:16.
// [R04] Slope codes 00, 01, 10 limit phase slope to 61, 7.5, 0.885 us/s; code 11 is unlimited.
// [R05] Setting bit 4 of the loop control register aligns output phase to the reference.
// [R06] Software holds the realignment bit low whenever hitless switching is needed.
// [R07] Bandwidth codes 000 to 110 select 14 up to 896 Hz, doubling each step.
// [R08] Bandwidth code 111 takes the bandwidth from the variable register at 0xbb; the bank does not decode 0xbb and drives LOOP_BW_HZ to 0.
// [R09] Multi-byte registers are big-endian: the lowest address carries the top byte.
// [R10] For a plain reference the frequency is base rate times multiplier.
// [R11] Software writes back the reset value into reserved bits 1:0.
`timescale 1ns/1ps
`include "dpllrc_map.vh"
module dpllrc_regs (
   input wire CLK_SYS,
   input wire RST,
   input wire REG_WR,
   input wire REG_RD,
   input wire [7:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   output reg [7:0] REG_RDATA,
   input wire [15:0] INPUT3_BASE_RATE,
   input wire [15:0] INPUT3_RATE_MULTIPLIER,
   output reg [15:0] INPUT3_FEC_NUMERATOR,
   output reg [15:0] INPUT3_FEC_DENOMINATOR,
   output wire [47:0] INPUT3_REF_FREQ_HZ,
   output wire FREQ_CALC_BUSY,
   output reg [1:0] PHASE_SLOPE_SEL,
   output reg SLOPE_UNLIMITED,
   output reg PHASE_REALIGN,
   output reg [2:0] LOOP_BW_SEL,
   output reg USE_VARIABLE_BW,
   output reg [9:0] LOOP_BW_HZ
);
   // ==========================================================
   // Register storage
   // ==========================================================
   // Register port is driven by the on-chip serial management engine on
   // this same clock, so no synchronisers are placed on it.
   // Each ratio byte is its own register so that every bit has a single driver
   wire [31:0] ratio_q;
   wire [31:0] ratio_rst = `DPLLRC_RATIO_RESET;
   reg [7:0] loop_ctrl_q;
   reg recalc_q;
   wire ratio_hit = (REG_ADDR >= `DPLLRC_ADDR_RATIO_B0) && (REG_ADDR <= `DPLLRC_ADDR_RATIO_B3);
   wire [1:0] byte_idx = REG_ADDR[1:0];
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_ratio_byte
         // Address 0x2c is byte 3 (most significant); 0x2f is byte 0
         localparam integer BYTE_SEL = 3 - gi;
         reg [7:0] byte_q;
         always @(posedge CLK_SYS) begin
            if (RST) begin
               byte_q <= ratio_rst[gi*8 +: 8]; // [R02]
            end else if (REG_WR && ratio_hit && (byte_idx == BYTE_SEL[1:0])) begin
               byte_q <= REG_WDATA; // [R09]
            end
         end
         assign ratio_q[gi*8 +: 8] = byte_q;
      end
   endgenerate
   always @(posedge CLK_SYS) begin
      if (RST) begin
         loop_ctrl_q <= `DPLLRC_LOOP_CTRL_RESET;
      end else if (REG_WR && REG_ADDR == `DPLLRC_ADDR_LOOP_CTRL) begin
         loop_ctrl_q <= REG_WDATA;
      end
   end
   // Recompute frequency after any write to the ratio word and after reset
   always @(posedge CLK_SYS) begin
      if (RST) begin
         recalc_q <= 1'b1;
      end else begin
         recalc_q <= REG_WR && ratio_hit;
      end
   end
   // ==========================================================
   // Read-back
   // ==========================================================
   always @(posedge CLK_SYS) begin
      if (RST) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         if (ratio_hit) begin
            REG_RDATA <= ratio_q[(3 - byte_idx)*8 +: 8]; // [R09]
         end else if (REG_ADDR == `DPLLRC_ADDR_LOOP_CTRL) begin
            REG_RDATA <= loop_ctrl_q;
         end else begin
            REG_RDATA <= 8'h00;
         end
      end
   end
   // ==========================================================
   // Decoded loop settings
   // ==========================================================
   always @(posedge CLK_SYS) begin
      if (RST) begin
         // Decoded view of the reset words, so outputs do not step after release
         INPUT3_FEC_NUMERATOR <= `DPLLRC_FEC_ONE; // [R02]
         INPUT3_FEC_DENOMINATOR <= `DPLLRC_FEC_ONE; // [R02]
         PHASE_SLOPE_SEL <= `DPLLRC_SLOPE_UNLIMITED;
         SLOPE_UNLIMITED <= 1'b1;
         PHASE_REALIGN <= 1'b0;
         LOOP_BW_SEL <= 3'h0;
         USE_VARIABLE_BW <= 1'b0;
         LOOP_BW_HZ <= `DPLLRC_BW_BASE_HZ;
      end else begin
         INPUT3_FEC_NUMERATOR <= ratio_q[`DPLLRC_NUMER_MSB:`DPLLRC_NUMER_LSB]; // [R03]
         INPUT3_FEC_DENOMINATOR <= ratio_q[`DPLLRC_DENOM_MSB:`DPLLRC_DENOM_LSB]; // [R03]
         PHASE_SLOPE_SEL <= loop_ctrl_q[`DPLLRC_SLOPE_MSB:`DPLLRC_SLOPE_LSB]; // [R04]
         SLOPE_UNLIMITED <= loop_ctrl_q[`DPLLRC_SLOPE_MSB:`DPLLRC_SLOPE_LSB]
            == `DPLLRC_SLOPE_UNLIMITED; // [R04]
         PHASE_REALIGN <= loop_ctrl_q[`DPLLRC_REALIGN_BIT]; // [R05]
         LOOP_BW_SEL <= loop_ctrl_q[`DPLLRC_BW_MSB:`DPLLRC_BW_LSB]; // [R07]
         USE_VARIABLE_BW <= loop_ctrl_q[`DPLLRC_BW_MSB:`DPLLRC_BW_LSB]
            == `DPLLRC_BW_VARIABLE; // [R08]
         // 14 Hz doubled per code step; zero flags the variable-bandwidth path
         if (loop_ctrl_q[`DPLLRC_BW_MSB:`DPLLRC_BW_LSB] == `DPLLRC_BW_VARIABLE) begin
            LOOP_BW_HZ <= 10'd0; // [R08]
         end else begin
            LOOP_BW_HZ <= `DPLLRC_BW_BASE_HZ << loop_ctrl_q[`DPLLRC_BW_MSB:`DPLLRC_BW_LSB]; // [R07]
         end
      end
   end
   // ==========================================================
   // Frequency calculation
   // ==========================================================
   dpllrc_freq_calc u_calc (
      .clk(CLK_SYS),
      .rst(RST),
      .start(recalc_q),
      .base_rate_value(INPUT3_BASE_RATE),
      .base_multiplier_value(INPUT3_RATE_MULTIPLIER),
      .fec_numerator_value(ratio_q[`DPLLRC_NUMER_MSB:`DPLLRC_NUMER_LSB]),
      .fec_denominator_value(ratio_q[`DPLLRC_DENOM_MSB:`DPLLRC_DENOM_LSB]),
      .ref_freq_hz(INPUT3_REF_FREQ_HZ),
      .busy(FREQ_CALC_BUSY)
   ); // [R01]
endmodule // dpllrc_regs

// ### dpllrc_regs_sva.sv
// Checker for the loop ratio and control register bank
`timescale 1ns/1ps
module dpllrc_sva_chk (
   input wire CLK_SYS, RST, REG_WR,
   input wire [7:0] REG_ADDR, REG_WDATA,
   input wire [15:0] INPUT3_BASE_RATE, INPUT3_RATE_MULTIPLIER,
   input wire [15:0] INPUT3_FEC_NUMERATOR, INPUT3_FEC_DENOMINATOR,
   input wire [47:0] INPUT3_REF_FREQ_HZ,
   input wire FREQ_CALC_BUSY, SLOPE_UNLIMITED, PHASE_REALIGN, USE_VARIABLE_BW,
   input wire [1:0] PHASE_SLOPE_SEL,
   input wire [9:0] LOOP_BW_HZ
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   wire ctl_wr = REG_WR && REG_ADDR == 8'h30;
   property p_slope;
      ctl_wr |-> ##2 PHASE_SLOPE_SEL == $past(REG_WDATA[3:2], 2)
         && SLOPE_UNLIMITED == ($past(REG_WDATA[3:2], 2) == 2'h3);
   endproperty
   a_slope: assert property (p_slope) else $error("slope mismatch");
   property p_realign;
      ctl_wr |-> ##2 PHASE_REALIGN == $past(REG_WDATA[4], 2);
   endproperty
   a_realign: assert property (p_realign) else $error("realign mismatch");
   property p_bw;
      ctl_wr && REG_WDATA[7:5] != 3'h7 |-> ##2 !USE_VARIABLE_BW
         && LOOP_BW_HZ == 10'h00e << $past(REG_WDATA[7:5], 2);
   endproperty
   a_bw: assert property (p_bw) else $error("bandwidth mismatch");
   property p_var;
      ctl_wr && REG_WDATA[7:5] == 3'h7 |-> ##2 USE_VARIABLE_BW && LOOP_BW_HZ == 10'h000;
   endproperty
   a_var: assert property (p_var) else $error("variable bw mismatch");
   property p_hi;
      REG_WR && REG_ADDR == 8'h2c |-> ##2 INPUT3_FEC_NUMERATOR[15:8] == $past(REG_WDATA, 2);
   endproperty
   a_hi: assert property (p_hi) else $error("top byte misplaced");
   property p_lo;
      REG_WR && REG_ADDR == 8'h2f |-> ##2 INPUT3_FEC_DENOMINATOR[7:0] == $past(REG_WDATA, 2);
   endproperty
   a_lo: assert property (p_lo) else $error("low byte misplaced");
   property p_freq;
      $fell(FREQ_CALC_BUSY) |-> ##2 INPUT3_REF_FREQ_HZ == INPUT3_BASE_RATE
         * INPUT3_RATE_MULTIPLIER * INPUT3_FEC_NUMERATOR / INPUT3_FEC_DENOMINATOR;
   endproperty
   a_freq: assert property (p_freq) else $error("frequency mismatch");
   property p_busy;
      $rose(FREQ_CALC_BUSY) |-> ##[40:60] !FREQ_CALC_BUSY;
   endproperty
   a_busy: assert property (p_busy) else $error("calculation hung");
   c_var: cover property (ctl_wr && REG_WDATA[7:5] == 3'h7);
   c_ratio: cover property (REG_WR && REG_ADDR == 8'h2c);
   c_calc: cover property ($fell(FREQ_CALC_BUSY));
endmodule // dpllrc_sva_chk
bind dpllrc_regs dpllrc_sva_chk u_chk (.CLK_SYS, .RST, .REG_WR, .REG_ADDR, .REG_WDATA,
   .INPUT3_BASE_RATE, .INPUT3_RATE_MULTIPLIER, .INPUT3_FEC_NUMERATOR,
   .INPUT3_FEC_DENOMINATOR, .INPUT3_REF_FREQ_HZ, .FREQ_CALC_BUSY, .SLOPE_UNLIMITED,
   .PHASE_REALIGN, .USE_VARIABLE_BW, .PHASE_SLOPE_SEL, .LOOP_BW_HZ);

// ### dpllrc_tb.sv
// Self-checking bench for the loop ratio and control register bank
`timescale 1ns/1ps
module testbench;
   logic CLK_SYS = 0, RST = 1, REG_WR, REG_RD, busy, unl, rl, uvar;
   logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, rb;
   logic [15:0] base = 16'h9c40, mult = 16'h0f30, num, den;
   logic [47:0] freq;
   logic [1:0] sl;
   logic [2:0] bsel;
   logic [9:0] bw;
   integer err_total = 0, n_compared = 0;
   always #20 CLK_SYS = ~CLK_SYS;
   dpllrc_regs u_dpllrc_regs (.CLK_SYS, .RST, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA,
      .REG_RDATA, .INPUT3_BASE_RATE(base), .INPUT3_RATE_MULTIPLIER(mult),
      .INPUT3_FEC_NUMERATOR(num), .INPUT3_FEC_DENOMINATOR(den), .INPUT3_REF_FREQ_HZ(freq),
      .FREQ_CALC_BUSY(busy), .PHASE_SLOPE_SEL(sl), .SLOPE_UNLIMITED(unl),
      .PHASE_REALIGN(rl), .LOOP_BW_SEL(bsel), .USE_VARIABLE_BW(uvar), .LOOP_BW_HZ(bw));
   dpllrc_host u_host (.clk(CLK_SYS), .rdata(REG_RDATA), .wr(REG_WR), .rd(REG_RD),
      .addr(REG_ADDR), .wdata(REG_WDATA));
   task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task close_out;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task calc; // Bounded wait for the divider, then let the result land
      integer i;
      repeat (3) @(negedge CLK_SYS);
      for (i = 0; i < 100 && busy !== 1'b0; i++) @(negedge CLK_SYS);
      chk("busy", 48'h0, busy);
      repeat (2) @(negedge CLK_SYS);
   endtask
   task t_reset;
      integer a;
      logic [39:0] dflt;
      dflt = 40'h000100010c;
      for (a = 0; a < 5; a++) begin
         u_host.rd8(8'h2c + a[7:0], rb);
         chk("reset byte", dflt[39 - 8 * a -: 8], rb);
      end
      chk("unlimited", 48'h1, unl);
      chk("bw hz", 48'h00e, bw);
      chk("bw sel", 48'h0, bsel);
      calc;
      chk("plain freq", base * mult, freq);
   endtask
   task t_fec;
      u_host.wr32(8'h2c, 32'h00ff00ed);
      calc;
      chk("numerator", 48'h00ff, num);
      chk("denominator", 48'h00ed, den);
      chk("fec freq", base * mult * 16'h00ff / 16'h00ed, freq);
      u_host.rd8(8'h2d, rb);
      chk("ratio byte", 48'hff, rb);
      u_host.wr32(8'h2c, 32'h00010001);
      calc;
      chk("plain freq", base * mult, freq);
   endtask
   task t_loop;
      integer c;
      for (c = 0; c < 8; c++) begin
         u_host.ctl(c[2:0], c[2], c[1:0]);
         u_host.rd8(8'h30, rb);
         chk("ctrl byte", {c[2:0], c[2], c[1:0], 2'b00}, rb);
         chk("slope", c[1:0], sl);
         chk("unlimited", c[1:0] == 2'h3, unl);
         chk("realign", c[2], rl);
         chk("variable", c == 7, uvar);
         chk("bw sel", c[2:0], bsel);
         chk("bw hz", c == 7 ? 48'h0 : 48'h00e << c[2:0], bw);
      end
      u_host.ctl(3'h0, 1'b0, 2'h3); // Hitless switching kept
   endtask
   task t_unmapped;
      u_host.wr8(8'h31, 8'hff);
      u_host.rd8(8'h31, rb);
      chk("unmapped", 48'h0, rb);
      u_host.rd8(8'h30, rb);
      chk("ctrl kept", 48'h0c, rb);
   endtask
   initial begin
      repeat (8) @(negedge CLK_SYS);
      RST = 0;
      t_reset;
      t_fec;
      t_loop;
      t_unmapped;
      close_out;
   end
   initial begin
      #100000;
      err_total++;
      close_out;
   end
endmodule // testbench
